// [hdl/itd_dispatch.sv]
`timescale 1ns/1ns
// How it works
// [RULE_01] Non-vectored kinds load one dedicated status block
// [RULE_02] Block chosen only by kind, fixed order
// [RULE_03] Block is two or four words
// [RULE_04] Vectored interrupts share one flags word
// [RULE_05] Identifier low byte indexes vectored PC table
// [RULE_06] Index zero picks first PC, consecutively
// [RULE_07] Pointer holds segment and offset high byte
// [RULE_08] Table offset low byte forced zero
// [RULE_09] Pointer reached only by load-control instruction
// [RULE_10] System reset overrides everything else
// [RULE_11] Segmented reset fetches four words at zero
// [RULE_12] Nonsegmented reset fetches two words at two
// [RULE_13] System and segmentation mode during reset
// [RULE_14] Reset pushes nothing onto the stack
// [RULE_15] Force modes, push status and identifier first
// [RULE_16] Identifier from bus or trapping instruction
// [RULE_17] Priority: traps, NMI, segment, vectored, non-vectored
// [RULE_18] Maskable interrupts need enable bit; NMI never masked
// [RULE_19] Flags word first, then PC words ascending
module itd_dispatch
   import itd_pkg::*;
#(
   parameter bit SEGMENTED = 1'b0
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic en,
   input wire logic insn_boundary,
   input wire logic trap_req,
   input wire logic [1:0] trap_kind,
   input wire logic [15:0] trap_instr_word,
   input wire logic nmi_req,
   input wire logic segtrap_req,
   input wire logic vi_req,
   input wire logic nvi_req,
   input wire logic [15:0] cur_fcw,
   input wire logic [6:0] cur_pc_seg,
   input wire logic [15:0] cur_pc_off,
   input wire logic [6:0] sp_seg,
   input wire logic [15:0] sp_off,
   input wire logic iack_valid,
   input wire logic [15:0] iack_data,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic ctl_status_table_pointer_we,
   input wire logic ctl_status_table_pointer_sel,
   input wire logic [15:0] ctl_status_table_pointer_wdata,
   output logic busy,
   output logic iack_req,
   output logic mem_req,
   output logic mem_we,
   output logic [6:0] mem_seg,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic ps_load,
   output logic [15:0] new_fcw,
   output logic [6:0] new_pc_seg,
   output logic [15:0] new_pc_off,
   output logic [15:0] new_sp_off,
   output logic sys_mode,
   output logic seg_mode,
   output logic [15:0] status_table_pointer_rdata
);

   localparam logic [15:0] RST_ADDR = SEGMENTED ? RST_ADDR_SEG : RST_ADDR_NS;
   localparam logic [2:0] RST_WORDS = SEGMENTED ? RST_WORDS_SEG : RST_WORDS_NS;
   localparam logic [2:0] LOAD_WORDS = SEGMENTED ? LOAD_WORDS_SEG : LOAD_WORDS_NS;
   localparam logic [2:0] PUSH_WORDS = SEGMENTED ? PUSH_WORDS_SEG : PUSH_WORDS_NS;
   localparam logic [15:0] VI_PC_START = SEGMENTED ? VI_PC_START_SEG : VI_PC_START_NS;

   typedef struct packed {
      itd_state_t state;
      logic is_reset;
      logic is_vi;
      logic [2:0] widx;
      logic [2:0] nwords;
      logic [2:0] blk;
      logic [15:0] ident;
      logic [15:0] sv_fcw;
      logic [6:0] sv_pc_seg;
      logic [15:0] sv_pc_off;
      logic [6:0] stk_seg;
      logic [15:0] stk_off;
      logic [15:0] nfcw;
      logic [6:0] npc_seg;
      logic [15:0] npc_off;
      logic [15:0] nsp;
      logic [6:0] mseg;
      logic [15:0] maddr;
      logic [15:0] mwdata;
      logic load;
      logic [6:0] status_table_pointer_seg;
      logic [7:0] status_table_pointer_hi;
      logic [15:0] status_table_pointer_rd;
   } itd_regs_t;

   itd_regs_t st_reg;
   itd_regs_t st_next;
   logic arb_take;
   logic arb_internal;
   logic arb_vi;
   logic [2:0] arb_blk;

   // Byte offset of a status block inside the table
   function automatic logic [15:0] blk_off(input logic [2:0] b);
      if (SEGMENTED) blk_off = {10'h000, b, 3'h0}; // [RULE_03]
      else blk_off = {11'h000, b, 2'h0}; // [RULE_03]
   endfunction

   // Table base: low byte of the offset is always zero
   function automatic logic [15:0] table_base(input logic [7:0] hi);
      table_base = {hi, 8'h00}; // [RULE_08]
   endfunction

   // Byte offset of vectored PC entry for an index
   function automatic logic [15:0] vi_off(input logic [7:0] idx);
      if (SEGMENTED) vi_off = {6'h00, idx, 2'h0}; // [RULE_06]
      else vi_off = {7'h00, idx, 1'b0}; // [RULE_06]
   endfunction

   // Address of the word that the state in r is about to move
   function automatic logic [15:0] word_addr(input itd_regs_t r);
      logic [15:0] k;
      logic [15:0] base;
      k = {12'h000, r.widx, 1'b0};
      base = table_base(r.status_table_pointer_hi) + blk_off(r.blk);
      if (r.state == ITD_PUSH) word_addr = r.stk_off - k - WORD_BYTES; // [RULE_15]
      else if (r.is_reset) word_addr = RST_ADDR + k; // [RULE_11] [RULE_12]
      else if (r.is_vi && r.widx != 3'h0) word_addr = base + VI_PC_START + vi_off(r.ident[7:0]) + k - WORD_BYTES; // [RULE_05]
      else word_addr = base + k; // [RULE_19] [RULE_01]
   endfunction

   // Word written on each push step, highest address first
   function automatic logic [15:0] push_word(input itd_regs_t r);
      push_word = 16'h0000;
      if (SEGMENTED) begin
         case (r.widx)
            3'h0: push_word = r.sv_pc_off;
            3'h1: push_word = {1'b0, r.sv_pc_seg, 8'h00};
            3'h2: push_word = r.sv_fcw;
            default: push_word = r.ident;
         endcase
      end else begin
         case (r.widx)
            3'h0: push_word = r.sv_pc_off;
            3'h1: push_word = r.sv_fcw;
            default: push_word = r.ident;
         endcase
      end
   endfunction

   itd_arbiter u_arb (
      .trap_req(trap_req),
      .trap_kind(trap_kind),
      .nmi_req(nmi_req),
      .segtrap_req(segtrap_req),
      .vi_req(vi_req),
      .nvi_req(nvi_req),
      .vi_enable(cur_fcw[FCW_VIE_BIT]),
      .nvi_enable(cur_fcw[FCW_NVIE_BIT]),
      .take(arb_take),
      .internal(arb_internal),
      .is_vi(arb_vi),
      .blk(arb_blk)
   );

   // Next state of the whole block
   always_comb begin
      st_next = st_reg;
      st_next.load = 1'b0;
      // Pointer read path; only the load-control port reaches it
      if (ctl_status_table_pointer_sel == STATUS_TABLE_POINTER_SEL_SEGMENT) st_next.status_table_pointer_rd = {1'b0, st_reg.status_table_pointer_seg, 8'h00}; // [RULE_07] [RULE_09]
      else st_next.status_table_pointer_rd = table_base(st_reg.status_table_pointer_hi); // [RULE_08]
      if (ctl_status_table_pointer_we) begin // [RULE_09]
         if (ctl_status_table_pointer_sel == STATUS_TABLE_POINTER_SEL_SEGMENT) begin
            if (SEGMENTED) st_next.status_table_pointer_seg = ctl_status_table_pointer_wdata[14:8]; // [RULE_07]
         end else begin
            st_next.status_table_pointer_hi = ctl_status_table_pointer_wdata[15:8]; // [RULE_07]
         end
      end
      case (st_reg.state)
         ITD_IDLE: begin
            if (insn_boundary && arb_take) begin
               st_next.blk = arb_blk; // [RULE_02]
               st_next.is_vi = arb_vi; // [RULE_04]
               st_next.is_reset = 1'b0;
               st_next.widx = 3'h0;
               st_next.sv_fcw = cur_fcw;
               st_next.sv_pc_seg = cur_pc_seg;
               st_next.sv_pc_off = cur_pc_off;
               st_next.stk_seg = sp_seg;
               st_next.stk_off = sp_off;
               st_next.ident = trap_instr_word; // [RULE_16]
               st_next.state = arb_internal ? ITD_PUSH : ITD_ACK;
            end
         end
         ITD_ACK: begin
            // Peripheral holds its identifier on the bus during acknowledge
            if (iack_valid) begin
               st_next.ident = iack_data; // [RULE_16]
               st_next.state = ITD_PUSH;
            end
         end
         ITD_PUSH: begin
            if (mem_ack) begin
               if (st_reg.widx == PUSH_WORDS - 3'h1) begin // [RULE_15]
                  st_next.nsp = st_reg.maddr;
                  st_next.widx = 3'h0;
                  st_next.nwords = LOAD_WORDS;
                  st_next.state = ITD_FETCH;
               end else begin
                  st_next.widx = st_reg.widx + 3'h1;
               end
            end
         end
         ITD_FETCH: begin
            if (mem_ack) begin
               // Flags word first, then segment (segmented build only) and offset of the PC
               if (st_reg.widx == 3'h0) st_next.nfcw = mem_rdata; // [RULE_19] [RULE_04]
               else if (SEGMENTED && st_reg.widx == 3'h1) st_next.npc_seg = mem_rdata[14:8];
               else if (st_reg.widx == LOAD_WORDS - 3'h1) st_next.npc_off = mem_rdata; // [RULE_01]
               if (st_reg.widx == st_reg.nwords - 3'h1) st_next.state = ITD_DONE;
               else st_next.widx = st_reg.widx + 3'h1;
            end
         end
         ITD_DONE: begin
            st_next.load = 1'b1; // [RULE_01]
            st_next.is_reset = 1'b0;
            st_next.state = ITD_IDLE;
         end
         default: st_next.state = ITD_IDLE;
      endcase
      st_next.maddr = word_addr(st_next);
      st_next.mwdata = (st_next.state == ITD_PUSH) ? push_word(st_next) : 16'h0000;
      if (st_next.state == ITD_PUSH) st_next.mseg = st_next.stk_seg;
      else if (st_next.is_reset) st_next.mseg = RST_SEG_NUM; // [RULE_11]
      else st_next.mseg = st_next.status_table_pointer_seg;
   end

   // Synchronous reset starts the reset fetch directly, skipping the push
   always_ff @(posedge clock) begin
      if (rst) begin // [RULE_10]
         st_reg <= '0;
         st_reg.state <= ITD_FETCH; // [RULE_14]
         st_reg.is_reset <= 1'b1;
         st_reg.nwords <= RST_WORDS; // [RULE_11] [RULE_12]
         st_reg.maddr <= RST_ADDR;
         st_reg.mseg <= RST_SEG_NUM;
      end else if (en) begin
         st_reg <= st_next;
      end
   end

   // Handshakes decode the state; data comes straight from flops
   assign busy = (st_reg.state != ITD_IDLE);
   assign iack_req = (st_reg.state == ITD_ACK);
   assign mem_req = (st_reg.state == ITD_PUSH) || (st_reg.state == ITD_FETCH);
   assign mem_we = (st_reg.state == ITD_PUSH); // [RULE_14]
   assign mem_seg = SEGMENTED ? st_reg.mseg : 7'h00;
   assign mem_addr = st_reg.maddr;
   assign mem_wdata = st_reg.mwdata;
   assign ps_load = st_reg.load;
   assign new_fcw = st_reg.nfcw;
   assign new_pc_seg = st_reg.npc_seg;
   assign new_pc_off = st_reg.npc_off;
   assign new_sp_off = st_reg.nsp;
   assign status_table_pointer_rdata = st_reg.status_table_pointer_rd;
   // Modes are forced for the whole sequence, reset included
   assign sys_mode = busy | cur_fcw[FCW_SYS_BIT]; // [RULE_13] [RULE_15]
   assign seg_mode = SEGMENTED & (busy | cur_fcw[FCW_SEG_BIT]); // [RULE_13]

   a_reset_start: assert property (@(posedge clock) $fell(rst) |-> mem_req && !mem_we // [RULE_11] [RULE_12]
      && mem_addr == RST_ADDR && mem_seg == 7'h00) else $error("reset fetch not at fixed address");
   a_reset_no_push: assert property (@(posedge clock) disable iff (rst) st_reg.is_reset |-> !mem_we) // [RULE_14]
      else $error("stack write during reset");
   a_mode_forced: assert property (@(posedge clock) busy |-> sys_mode && (seg_mode == SEGMENTED)) // [RULE_13]
      else $error("modes not forced while busy");
   a_trap_first: assert property (@(posedge clock) disable iff (rst) (st_reg.state == ITD_IDLE) && en // [RULE_17]
      && insn_boundary && trap_req && nmi_req |=> st_reg.state == ITD_PUSH && st_reg.ident == $past(trap_instr_word))
      else $error("internal trap lost priority");
   a_vi_masked: assert property (@(posedge clock) disable iff (rst) (st_reg.state == ITD_IDLE) && en // [RULE_18]
      && insn_boundary && vi_req && !cur_fcw[FCW_VIE_BIT] && !trap_req && !nmi_req && !segtrap_req
      && !(nvi_req && cur_fcw[FCW_NVIE_BIT]) |=> st_reg.state == ITD_IDLE)
      else $error("masked vectored interrupt taken");
   a_status_table_pointer_low_zero: assert property (@(posedge clock) disable iff (rst) status_table_pointer_rdata[7:0] == 8'h00) // [RULE_08]
      else $error("pointer low byte not zero");
   a_block_first: assert property (@(posedge clock) disable iff (rst) // [RULE_02] [RULE_19]
      (st_reg.state == ITD_FETCH) && !st_reg.is_reset && st_reg.widx == 3'h0
      |-> mem_addr == table_base(st_reg.status_table_pointer_hi) + blk_off(st_reg.blk)) else $error("flags word address wrong");
   a_vi_index: assert property (@(posedge clock) disable iff (rst) (st_reg.state == ITD_FETCH) // [RULE_05] [RULE_06]
      && st_reg.is_vi && !st_reg.is_reset && st_reg.widx == 3'h1 |-> mem_addr == table_base(st_reg.status_table_pointer_hi)
      + blk_off(BLK_VI) + VI_PC_START + vi_off(st_reg.ident[7:0])) else $error("vectored PC address wrong");
   a_push_then_load: assert property (@(posedge clock) disable iff (rst) $rose(st_reg.state == ITD_FETCH) // [RULE_15]
      && !st_reg.is_reset |-> st_reg.nsp == $past(sp_off, 1) - {12'h000, PUSH_WORDS, 1'b0} || !en)
      else $error("push count wrong");

endmodule

// [hdl/itd_pkg.sv]
package itd_pkg;

   // Flags and control word bit positions
   localparam int FCW_SEG_BIT = 15;
   localparam int FCW_SYS_BIT = 14;
   localparam int FCW_VIE_BIT = 12;
   localparam int FCW_NVIE_BIT = 11;

   // Word geometry
   localparam logic [15:0] WORD_BYTES = 16'h0002;
   localparam logic [2:0] BLK_SHIFT_NS = 3'h2;   // Two words per status block
   localparam logic [2:0] BLK_SHIFT_SEG = 3'h3;  // Four words per status block

   // Reset fetch
   localparam logic [15:0] RST_ADDR_NS = 16'h0002;
   localparam logic [15:0] RST_ADDR_SEG = 16'h0000;
   localparam logic [6:0] RST_SEG_NUM = 7'h00;
   localparam logic [2:0] RST_WORDS_NS = 3'h2;
   localparam logic [2:0] RST_WORDS_SEG = 3'h4;

   // Words loaded from a table block, words pushed on the stack
   localparam logic [2:0] LOAD_WORDS_NS = 3'h2;
   localparam logic [2:0] LOAD_WORDS_SEG = 3'h3;
   localparam logic [2:0] PUSH_WORDS_NS = 3'h3;
   localparam logic [2:0] PUSH_WORDS_SEG = 3'h4;

   // Status block order inside the table
   localparam logic [2:0] BLK_UNIMPL = 3'h1;
   localparam logic [2:0] BLK_PRIV = 3'h2;
   localparam logic [2:0] BLK_SYSCALL = 3'h3;
   localparam logic [2:0] BLK_SEGTRAP = 3'h4;
   localparam logic [2:0] BLK_NMI = 3'h5;
   localparam logic [2:0] BLK_NVI = 3'h6;
   localparam logic [2:0] BLK_VI = 3'h7;

   // Offset of the first vectored program counter inside the vectored block
   localparam logic [15:0] VI_PC_START_NS = 16'h0002;
   localparam logic [15:0] VI_PC_START_SEG = 16'h0004;

   // Internal trap kinds
   localparam logic [1:0] TRAP_UNIMPL = 2'h0;
   localparam logic [1:0] TRAP_PRIV = 2'h1;
   localparam logic [1:0] TRAP_SYSCALL = 2'h2;

   // Status table pointer word select
   localparam logic STATUS_TABLE_POINTER_SEL_OFFSET = 1'b0;
   localparam logic STATUS_TABLE_POINTER_SEL_SEGMENT = 1'b1;

   typedef enum logic [4:0] {
      ITD_IDLE = 5'b00001,
      ITD_ACK = 5'b00010,
      ITD_PUSH = 5'b00100,
      ITD_FETCH = 5'b01000,
      ITD_DONE = 5'b10000
   } itd_state_t;

endpackage

// [hdl/itd_arbiter.sv]
`timescale 1ns/1ns
module itd_arbiter
   import itd_pkg::*;
(
   input wire logic trap_req,
   input wire logic [1:0] trap_kind,
   input wire logic nmi_req,
   input wire logic segtrap_req,
   input wire logic vi_req,
   input wire logic nvi_req,
   input wire logic vi_enable,
   input wire logic nvi_enable,
   output logic take,
   output logic internal,
   output logic is_vi,
   output logic [2:0] blk
);

   // Fixed priority; masked interrupts simply do not compete
   always_comb begin
      take = 1'b1;
      internal = 1'b0;
      is_vi = 1'b0;
      blk = BLK_NMI;
      if (trap_req) begin // [RULE_17]
         internal = 1'b1;
         case (trap_kind) // [RULE_02]
            TRAP_PRIV: blk = BLK_PRIV;
            TRAP_SYSCALL: blk = BLK_SYSCALL;
            default: blk = BLK_UNIMPL;  // Unknown kinds fall back to unimplemented
         endcase
      end else if (nmi_req) begin // [RULE_18]
         blk = BLK_NMI;
      end else if (segtrap_req) begin
         blk = BLK_SEGTRAP;
      end else if (vi_req && vi_enable) begin // [RULE_18]
         blk = BLK_VI;
         is_vi = 1'b1;
      end else if (nvi_req && nvi_enable) begin // [RULE_18]
         blk = BLK_NVI;
      end else begin
         take = 1'b0;
      end
   end

endmodule

// [verif/itd_far_model.sv]
`timescale 1ns/1ns
module itd_far_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic iack_req,
   input wire logic [15:0] ident,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   output logic iack_valid,
   output logic [15:0] iack_data
);
   logic [15:0] mem [0:32767];
   int wait_cnt;
   int n_writes;

   // Each word holds a pattern of its own byte address, so a wrong fetch shows
   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 16'(i * 2) ^ 16'hA5C3;
      end
   end

   // Memory answers one word per request; slow mode waits three cycles first
   // Released data lines toggle so stale values never pass for an answer
   always @(posedge clock) begin
      if (rst) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
         wait_cnt <= 0;
         n_writes <= 0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_we) begin
            mem[mem_addr[15:1]] <= mem_wdata;
            n_writes <= n_writes + 1;
         end
      end else if (mem_req && wait_cnt >= (slow ? 3 : 0)) begin
         mem_ack <= 1'b1;
         wait_cnt <= 0;
         mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[15:1]];
      end else begin
         wait_cnt <= mem_req ? wait_cnt + 1 : 0;
         mem_rdata <= ~mem_rdata;
      end
   end

   // Peripheral places its identifier while acknowledge is requested
   always @(posedge clock) begin
      if (rst) begin
         iack_valid <= 1'b0;
         iack_data <= 16'h0000;
      end else if (iack_valid || !iack_req) begin
         iack_valid <= 1'b0;
         iack_data <= ~iack_data;
      end else begin
         iack_valid <= 1'b1;
         iack_data <= ident;
      end
   end
endmodule

// [verif/interrupt_trap_status_dispatch_tb_top.sv]
`timescale 1ns/1ns
module interrupt_trap_status_dispatch_tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic insn_boundary = 1'b0, trap_req = 1'b0, nmi_req = 1'b0, segtrap_req = 1'b0, vi_req = 1'b0, nvi_req = 1'b0;
   logic [1:0] trap_kind = 2'h0;
   logic [15:0] trap_instr_word = 16'h0, cur_fcw = 16'h0, cur_pc_off = 16'h0, sp_off = 16'h0, ident = 16'h0;
   logic [15:0] ctl_status_table_pointer_wdata = 16'h0;
   logic [6:0] cur_pc_seg = 7'h0, sp_seg = 7'h0;
   logic ctl_status_table_pointer_we = 1'b0, ctl_status_table_pointer_sel = 1'b0, slow = 1'b0;
   logic iack_valid, mem_ack, busy, iack_req, mem_req, mem_we, ps_load, sys_mode, seg_mode;
   logic [15:0] iack_data, mem_rdata, mem_addr, mem_wdata, new_fcw, new_pc_off, new_sp_off, status_table_pointer_rdata;
   logic [6:0] mem_seg, new_pc_seg;
   logic [15:0] rnd = 16'h0062;
   logic [15:0] base, sp, fl, pc, idw, ent;
   logic [4:0] req;
   int n_mismatch = 0, checks_done = 0, cyc = 0, blk, pr;
   int blks [8] = '{1, 2, 3, 5, 4, 7, 6, 1};

   itd_dispatch #(.SEGMENTED(1'b0)) u_dut (
      .clock, .rst, .en, .insn_boundary, .trap_req, .trap_kind, .trap_instr_word, .nmi_req, .segtrap_req, .vi_req,
      .nvi_req, .cur_fcw, .cur_pc_seg, .cur_pc_off, .sp_seg, .sp_off, .iack_valid, .iack_data, .mem_ack, .mem_rdata,
      .ctl_status_table_pointer_we, .ctl_status_table_pointer_sel, .ctl_status_table_pointer_wdata, .busy, .iack_req, .mem_req, .mem_we, .mem_seg, .mem_addr,
      .mem_wdata, .ps_load, .new_fcw, .new_pc_seg, .new_pc_off, .new_sp_off, .sys_mode, .seg_mode, .status_table_pointer_rdata
   );

   itd_far_model u_far (
      .clock, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .iack_req, .ident, .mem_ack, .mem_rdata,
      .iack_valid, .iack_data
   );

   // 125 MHz clock
   always #4 clock = ~clock;

   // Hang guard, well above the several hundred cycles the run needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // Expected content of an untouched memory word at a byte address
   function automatic logic [15:0] pat(input logic [15:0] a);
      return a ^ 16'hA5C3;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for ps_load (which 0) or busy (which 1), sampled after the edge
   task automatic wait_for(input int which);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (((which == 0) ? ps_load : busy) !== 1'b1 && n < 300);
      check(16'(n < 300), 16'h1);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (11) @(posedge clock);
      #1;
      check(mem_addr, 16'h0002);
      check({15'h0, sys_mode}, 16'h1);
      check({15'h0, mem_we}, 16'h0);
      check({15'h0, seg_mode}, 16'h0);
      check({9'h0, mem_seg}, 16'h0);
      @(posedge clock);
      rst <= 1'b0;
      wait_for(0);
      check(new_fcw, pat(16'h0002));
      check(new_pc_off, pat(16'h0004));
      check(16'(u_far.n_writes), 16'h0);
      $display("test reset done");
      // Low byte of the written offset is junk and must be dropped
      @(posedge clock);
      rnd = lfsr(rnd);
      ctl_status_table_pointer_we <= 1'b1;
      ctl_status_table_pointer_wdata <= {2'b00, rnd[5:0] | 6'h10, rnd[15:8]};
      base = {2'b00, rnd[5:0] | 6'h10, 8'h00};
      @(posedge clock);
      ctl_status_table_pointer_we <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check(status_table_pointer_rdata, base);
      // Segment word does not exist without segmentation, so a write to it is dropped
      @(posedge clock);
      ctl_status_table_pointer_sel <= 1'b1;
      ctl_status_table_pointer_we <= 1'b1;
      @(posedge clock);
      ctl_status_table_pointer_we <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check(status_table_pointer_rdata, 16'h0000);
      @(posedge clock);
      ctl_status_table_pointer_sel <= 1'b0;
      $display("test pointer done");
      // Pass 0: each kind alone, prompt memory, index 0; pass 1: lower kinds too, slow memory, index 255
      for (int pass = 0; pass < 2; pass++) begin
         for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            blk = blks[k];
            pr = (k < 3 || k == 7) ? 0 : k - 2;
            req = pass ? ~((5'h1 << pr) - 5'h1) : (5'h1 << pr);
            sp = {4'hC, rnd[11:1], 1'b0};
            fl = (k == 5 || k == 6) ? (rnd | 16'h1800) & 16'hBFFF : rnd & 16'hA7FF;
            pc = lfsr(rnd);
            idw = {rnd[7:0], {8{pass[0]}}};
            @(posedge clock);
            slow <= pass[0];
            ident <= idw;
            trap_instr_word <= ~idw;
            cur_fcw <= fl;
            cur_pc_off <= pc;
            sp_off <= sp;
            trap_kind <= (k == 7) ? 2'h3 : k[1:0];
            {nvi_req, vi_req, segtrap_req, nmi_req, trap_req} <= req;
            insn_boundary <= 1'b1;
            wait_for(1);
            check({15'h0, sys_mode}, 16'h1);
            check({15'h0, iack_req}, {15'h0, ~req[0]});
            @(posedge clock);
            insn_boundary <= 1'b0;
            en <= !pass[0]; // Pass 1 also freezes the block for three cycles mid-dispatch
            #1;
            ent = mem_addr;
            repeat (3) @(posedge clock);
            en <= 1'b1;
            #1;
            if (pass) check(mem_addr, ent);
            wait_for(0);
            @(posedge clock);
            {nvi_req, vi_req, segtrap_req, nmi_req, trap_req} <= 5'h00;
            ent = base + 16'(blk * 4);
            check(new_fcw, pat(ent));
            check(new_pc_off, pat(ent + 16'h2 + ((blk == 7) ? {7'h0, idw[7:0], 1'b0} : 16'h0)));
            check(u_far.mem[15'((sp - 16'h2) >> 1)], pc);
            check(u_far.mem[15'((sp - 16'h4) >> 1)], fl);
            check(u_far.mem[15'((sp - 16'h6) >> 1)], req[0] ? ~idw : idw);
            check(new_sp_off, sp - 16'h6);
            check({9'h0, new_pc_seg}, 16'h0);
            $display("test dispatch %0d pass %0d done", k, pass);
         end
      end
      // Maskable requests with both enables clear must be ignored
      @(posedge clock);
      cur_fcw <= 16'h0000;
      vi_req <= 1'b1;
      nvi_req <= 1'b1;
      insn_boundary <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      check({15'h0, busy}, 16'h0);
      $display("test mask done");
      // Reset in mid-dispatch restarts the reset fetch
      @(posedge clock);
      {vi_req, nvi_req, nmi_req} <= 3'b001;
      wait_for(1);
      @(posedge clock);
      rst <= 1'b1;
      {nmi_req, insn_boundary} <= 2'b00;
      repeat (2) @(posedge clock);
      #1;
      check(mem_addr, 16'h0002);
      check({15'h0, mem_we}, 16'h0);
      @(posedge clock);
      rst <= 1'b0;
      wait_for(0);
      check(new_fcw, pat(16'h0002));
      $display("test rerun reset done");
      results();
   end
endmodule
